// >>> core/gpp_pkg.sv
// Purpose: Shared constants and carrier types for the six-pin port with pin steering.
// Assumes: 8-bit register port, byte-sized registers at small word indices.
// Notes:   Pin index 3 is input-only and has no driver, latch or analog control.
package gpp_pkg;

	localparam int unsigned GPP_NPINS = 6;
	localparam int unsigned GPP_AW    = 4;
	localparam int unsigned GPP_DW    = 8;

	typedef logic [GPP_AW-1:0]    gpp_addr_t;
	typedef logic [GPP_DW-1:0]    gpp_data_t;
	typedef logic [GPP_NPINS-1:0] gpp_pins_t;

	// Register offsets
	localparam gpp_addr_t GPP_OFS_PIN_LEVEL  = 4'h0;
	localparam gpp_addr_t GPP_OFS_DIRECTION  = 4'h1;
	localparam gpp_addr_t GPP_OFS_OUT_LATCH  = 4'h2;
	localparam gpp_addr_t GPP_OFS_ANALOG_SEL = 4'h3;
	localparam gpp_addr_t GPP_OFS_OPEN_DRAIN = 4'h4;
	localparam gpp_addr_t GPP_OFS_ALT_PIN    = 4'h5;

	// Pin indices
	localparam int unsigned GPP_PIN_ZERO  = 0;
	localparam int unsigned GPP_PIN_ONE   = 1;
	localparam int unsigned GPP_PIN_TWO   = 2;
	localparam int unsigned GPP_PIN_THREE = 3;
	localparam int unsigned GPP_PIN_FOUR  = 4;
	localparam int unsigned GPP_PIN_FIVE  = 5;

	// Implemented-bit masks and reset values
	localparam gpp_pins_t GPP_DIR_MASK     = 6'h37;
	localparam gpp_pins_t GPP_DIR_FIXED    = 6'h08;
	localparam gpp_pins_t GPP_DIR_RESET    = 6'h3f;
	localparam gpp_pins_t GPP_LAT_MASK     = 6'h37;
	localparam gpp_pins_t GPP_LAT_RESET    = 6'h00;
	localparam gpp_pins_t GPP_ANA_MASK     = 6'h17;
	localparam gpp_pins_t GPP_ANA_RESET    = 6'h17;
	localparam gpp_pins_t GPP_OD_MASK      = 6'h37;
	localparam gpp_pins_t GPP_OD_RESET     = 6'h00;
	localparam gpp_data_t GPP_ALT_MASK     = 8'hef;
	localparam gpp_data_t GPP_ALT_RESET    = 8'h00;

	// Alternate pin select field positions
	localparam int unsigned GPP_ALT_RX_SEL   = 7;
	localparam int unsigned GPP_ALT_WGA_SEL  = 6;
	localparam int unsigned GPP_ALT_WGB_SEL  = 5;
	localparam int unsigned GPP_ALT_TGATE_SEL = 3;
	localparam int unsigned GPP_ALT_TX_SEL   = 2;
	localparam int unsigned GPP_ALT_P2_SEL   = 1;
	localparam int unsigned GPP_ALT_P1_SEL   = 0;

	// Outputs of the steered peripherals, same clock domain
	typedef struct packed {
		logic rx_en;
		logic rx_dat;
		logic p2_en;
		logic p2_dat;
		logic tx_en;
		logic tx_dat;
		logic p1_en;
		logic p1_dat;
		logic wgb_en;
		logic wgb_dat;
		logic wga_en;
		logic wga_dat;
	} gpp_periph_out_s;

	// Pin levels handed back to the steered peripherals
	typedef struct packed {
		logic rx_dat;
		logic tx_clk;
		logic tmr_gate;
	} gpp_periph_in_s;

endpackage : gpp_pkg

// >>> core/gpp_port.sv
// Purpose: Six-pin general-purpose port with direction, latch, analog, open-drain and pin steering.
// Assumes: Peripheral signals are on clk_sys_i; pin inputs are asynchronous.
// Notes:   pins_oen_o is low while a pin is driven; pin three is never driven.
//
// Chosen here: the address map and the address-and-strobe port.
`timescale 1ns/10ps

module gpp_port (
	input  wire logic                     clk_sys_i,
	input  wire logic                     resetn_i,
	input  wire gpp_pkg::gpp_addr_t       reg_addr_i,
	input  wire gpp_pkg::gpp_data_t       reg_wdata_i,
	input  wire logic                     reg_we_i,
	input  wire logic                     reg_re_i,
	output var  gpp_pkg::gpp_data_t       reg_rdata_o,
	input  wire gpp_pkg::gpp_pins_t       pins_i,
	output var  gpp_pkg::gpp_pins_t       pins_o,
	output var  gpp_pkg::gpp_pins_t       pins_oen_o,
	input  wire gpp_pkg::gpp_periph_out_s periph_out_i,
	output var  gpp_pkg::gpp_periph_in_s  periph_in_o
);
	import gpp_pkg::*;

	// One-hot pin mask for a function steered between two pins
	function automatic gpp_pins_t pin_steer(input logic sel, input int unsigned pin_set,
		input int unsigned pin_clr);
		gpp_pins_t m;
		m = '0;
		if (sel) begin
			m[pin_set] = 1'b1;
		end else begin
			m[pin_clr] = 1'b1;
		end
		return m;
	endfunction : pin_steer

	gpp_pins_t       dir_r;
	gpp_pins_t       lat_r;
	gpp_pins_t       ana_r;
	gpp_pins_t       od_r;
	gpp_data_t       alt_r;
	gpp_pins_t       pin_sync;
	gpp_pins_t       pin_digital;
	gpp_pins_t       dir_view;
	gpp_pins_t       rx_mask;
	gpp_pins_t       wga_mask;
	gpp_pins_t       wgb_mask;
	gpp_pins_t       tx_mask;
	gpp_pins_t       p2_mask;
	gpp_pins_t       p1_mask;
	gpp_pins_t       ovr_en;
	gpp_pins_t       ovr_dat;
	gpp_pins_t       ovr_drv;
	gpp_pins_t       pin_dat_nxt;
	gpp_pins_t       pin_drv_nxt;
	gpp_pins_t       merged_nxt;
	gpp_data_t       rdata_nxt;
	gpp_periph_in_s  periph_in_nxt;
	logic            wr_pin_level;
	logic            wr_latch;

	gpp_sync u_sync (
		.clk_sys_i (clk_sys_i),
		.resetn_i  (resetn_i),
		.async_i   (pins_i),
		.sync_o    (pin_sync)
	);

	// Digital input buffer off on analog pins
	assign pin_digital = pin_sync & ~ana_r;

	assign dir_view = (dir_r & GPP_DIR_MASK) | GPP_DIR_FIXED;

	assign wr_pin_level = reg_we_i && (reg_addr_i == GPP_OFS_PIN_LEVEL);
	assign wr_latch     = reg_we_i && (reg_addr_i == GPP_OFS_OUT_LATCH);

	// Steering masks
	assign rx_mask  = pin_steer(alt_r[GPP_ALT_RX_SEL], GPP_PIN_FIVE, GPP_PIN_ONE);
	assign wga_mask = pin_steer(alt_r[GPP_ALT_WGA_SEL], GPP_PIN_FIVE, GPP_PIN_TWO);
	assign wgb_mask = pin_steer(alt_r[GPP_ALT_WGB_SEL], GPP_PIN_FOUR, GPP_PIN_ZERO);
	assign tx_mask  = pin_steer(alt_r[GPP_ALT_TX_SEL], GPP_PIN_FOUR, GPP_PIN_ZERO);
	assign p2_mask  = pin_steer(alt_r[GPP_ALT_P2_SEL], GPP_PIN_FOUR, GPP_PIN_ZERO);
	assign p1_mask  = pin_steer(alt_r[GPP_ALT_P1_SEL], GPP_PIN_FIVE, GPP_PIN_ONE);

	// Read-modify-write merge for pin-level writes
	always_comb begin
		merged_nxt = (pin_digital & ~GPP_LAT_MASK) | (reg_wdata_i[GPP_NPINS-1:0] & GPP_LAT_MASK);
	end

	always_ff @(posedge clk_sys_i) begin
		if (!resetn_i) begin
			dir_r <= GPP_DIR_RESET;
		end else if (reg_we_i && (reg_addr_i == GPP_OFS_DIRECTION)) begin
			dir_r <= (reg_wdata_i[GPP_NPINS-1:0] & GPP_DIR_MASK) | GPP_DIR_FIXED;
		end
	end

	always_ff @(posedge clk_sys_i) begin
		if (!resetn_i) begin
			lat_r <= GPP_LAT_RESET;
		end else if (wr_pin_level) begin
			lat_r <= merged_nxt & GPP_LAT_MASK;
		end else if (wr_latch) begin
			lat_r <= reg_wdata_i[GPP_NPINS-1:0] & GPP_LAT_MASK;
		end
	end

	always_ff @(posedge clk_sys_i) begin
		if (!resetn_i) begin
			ana_r <= GPP_ANA_RESET;
		end else if (reg_we_i && (reg_addr_i == GPP_OFS_ANALOG_SEL)) begin
			ana_r <= reg_wdata_i[GPP_NPINS-1:0] & GPP_ANA_MASK;
		end
	end

	always_ff @(posedge clk_sys_i) begin
		if (!resetn_i) begin
			od_r <= GPP_OD_RESET;
		end else if (reg_we_i && (reg_addr_i == GPP_OFS_OPEN_DRAIN)) begin
			od_r <= reg_wdata_i[GPP_NPINS-1:0] & GPP_OD_MASK;
		end
	end

	always_ff @(posedge clk_sys_i) begin
		if (!resetn_i) begin
			alt_r <= GPP_ALT_RESET;
		end else if (reg_we_i && (reg_addr_i == GPP_OFS_ALT_PIN)) begin
			alt_r <= reg_wdata_i & GPP_ALT_MASK;
		end
	end

	// Peripheral overrides, lowest priority first so the highest wins
	always_comb begin
		ovr_en  = '0;
		ovr_dat = '0;
		ovr_drv = '0;
		for (int unsigned p = 0; p < GPP_NPINS; p++) begin
			if (periph_out_i.rx_en && rx_mask[p]) begin
				ovr_en[p]  = 1'b1;
				ovr_dat[p] = periph_out_i.rx_dat;
				ovr_drv[p] = 1'b1;
			end
			if (periph_out_i.p2_en && p2_mask[p]) begin
				ovr_en[p]  = 1'b1;
				ovr_dat[p] = periph_out_i.p2_dat;
				ovr_drv[p] = 1'b0;
			end
			if (periph_out_i.tx_en && tx_mask[p]) begin
				ovr_en[p]  = 1'b1;
				ovr_dat[p] = periph_out_i.tx_dat;
				ovr_drv[p] = 1'b1;
			end
			if (periph_out_i.p1_en && p1_mask[p]) begin
				ovr_en[p]  = 1'b1;
				ovr_dat[p] = periph_out_i.p1_dat;
				ovr_drv[p] = 1'b0;
			end
			if (periph_out_i.wgb_en && wgb_mask[p]) begin
				ovr_en[p]  = 1'b1;
				ovr_dat[p] = periph_out_i.wgb_dat;
				ovr_drv[p] = 1'b0;
			end
			if (periph_out_i.wga_en && wga_mask[p]) begin
				ovr_en[p]  = 1'b1;
				ovr_dat[p] = periph_out_i.wga_dat;
				ovr_drv[p] = 1'b0;
			end
		end
	end

	// Per-pin driver: data from peripheral or latch, enable from direction or forced on by an rx or tx override
	for (genvar g = 0; g < GPP_NPINS; g++) begin : g_pin
		if (g == GPP_PIN_THREE) begin : g_input_only
			assign pin_dat_nxt[g] = 1'b0;
			assign pin_drv_nxt[g] = 1'b0;
		end else begin : g_io
			logic dat;
			logic drv;
			assign dat = ovr_en[g] ? ovr_dat[g] : lat_r[g];
			assign drv = ~dir_r[g] | ovr_drv[g];
			// Open-drain releases the pin instead of driving high
			assign pin_dat_nxt[g] = od_r[g] ? 1'b0 : dat;
			assign pin_drv_nxt[g] = drv & ~(od_r[g] & dat);
		end
	end

	always_ff @(posedge clk_sys_i) begin
		if (!resetn_i) begin
			pins_o     <= '0;
			pins_oen_o <= '1;
		end else begin
			pins_o     <= pin_dat_nxt;
			pins_oen_o <= ~pin_drv_nxt;
		end
	end

	// Peripheral inputs taken from the selected pin
	always_comb begin
		periph_in_nxt.rx_dat   = |(pin_digital & rx_mask);
		periph_in_nxt.tx_clk   = |(pin_digital & tx_mask);
		periph_in_nxt.tmr_gate = alt_r[GPP_ALT_TGATE_SEL] ? pin_digital[GPP_PIN_THREE]
			: pin_digital[GPP_PIN_FOUR];
	end

	always_ff @(posedge clk_sys_i) begin
		if (!resetn_i) begin
			periph_in_o <= '0;
		end else begin
			periph_in_o <= periph_in_nxt;
		end
	end

	// Register read mux
	always_comb begin
		rdata_nxt = '0;
		case (reg_addr_i)
			GPP_OFS_PIN_LEVEL: begin
				rdata_nxt[GPP_NPINS-1:0] = pin_digital;
			end
			GPP_OFS_DIRECTION: begin
				rdata_nxt[GPP_NPINS-1:0] = dir_view;
			end
			GPP_OFS_OUT_LATCH: begin
				rdata_nxt[GPP_NPINS-1:0] = lat_r;
			end
			GPP_OFS_ANALOG_SEL: begin
				rdata_nxt[GPP_NPINS-1:0] = ana_r;
			end
			GPP_OFS_OPEN_DRAIN: begin
				rdata_nxt[GPP_NPINS-1:0] = od_r;
			end
			GPP_OFS_ALT_PIN: begin
				rdata_nxt = alt_r & GPP_ALT_MASK;
			end
			default: begin
				rdata_nxt = '0;
			end
		endcase
	end

	always_ff @(posedge clk_sys_i) begin
		if (!resetn_i) begin
			reg_rdata_o <= '0;
		end else if (reg_re_i) begin
			reg_rdata_o <= rdata_nxt;
		end else begin
			reg_rdata_o <= '0;
		end
	end

endmodule : gpp_port

// >>> core/gpp_sync.sv
// Purpose: Two-stage synchroniser for the asynchronous pin levels.
// Assumes: Inputs are unrelated to clk_sys_i.
// Notes:   The first stage feeds only the second stage.
`timescale 1ns/10ps
module gpp_sync (
	input  wire logic                clk_sys_i,
	input  wire logic                resetn_i,
	input  wire gpp_pkg::gpp_pins_t  async_i,
	output var  gpp_pkg::gpp_pins_t  sync_o
);
	import gpp_pkg::*;

	gpp_pins_t meta_r;

	always_ff @(posedge clk_sys_i) begin
		if (!resetn_i) begin
			meta_r <= '0;
			sync_o <= '0;
		end else begin
			meta_r <= async_i;
			sync_o <= meta_r;
		end
	end

endmodule : gpp_sync

// >>> tb/gpp_pin_model.sv
// Purpose: Wire and outside-world model for the six port pins.
// Assumes: No pull resistors; a released pin shows the outside source.
// Notes:   A small delay keeps pin changes off the clock edge.
`timescale 1ns/10ps
module gpp_pin_model (
	input  wire gpp_pkg::gpp_pins_t out_i,
	input  wire gpp_pkg::gpp_pins_t oen_n_i,
	input  wire gpp_pkg::gpp_pins_t ext_i,
	output gpp_pkg::gpp_pins_t      wire_o
);
	// Driven bits follow the port, released bits the outside source
	assign #1 wire_o = (out_i & ~oen_n_i) | (ext_i & oen_n_i);
endmodule : gpp_pin_model

// >>> tb/gpp_port_monitor.sv
// Purpose: Port-level checks for the six-pin port.
// Assumes: Register writes seen at the ports are the only state source.
// Notes:   Mirrors analog and open-drain bits to judge reads and drives.
`timescale 1ns/10ps
module gpp_port_monitor (
	input wire logic               clk_sys_i,
	input wire logic               resetn_i,
	input wire gpp_pkg::gpp_addr_t reg_addr_i,
	input wire gpp_pkg::gpp_data_t reg_wdata_i,
	input wire logic               reg_we_i,
	input wire logic               reg_re_i,
	input wire gpp_pkg::gpp_data_t reg_rdata_o,
	input wire gpp_pkg::gpp_pins_t pins_o,
	input wire gpp_pkg::gpp_pins_t pins_oen_o
);
	import gpp_pkg::*;
	gpp_pins_t ana_r;
	gpp_pins_t od_r;
	default clocking @(posedge clk_sys_i); endclocking
	default disable iff (!resetn_i);
	// Mirror of the analog and open-drain registers
	always_ff @(posedge clk_sys_i) begin
		if (!resetn_i) begin
			ana_r <= GPP_ANA_RESET;
			od_r  <= GPP_OD_RESET;
		end else if (reg_we_i && reg_addr_i == GPP_OFS_ANALOG_SEL) begin
			ana_r <= reg_wdata_i[5:0] & GPP_ANA_MASK;
		end else if (reg_we_i && reg_addr_i == GPP_OFS_OPEN_DRAIN) begin
			od_r <= reg_wdata_i[5:0] & GPP_OD_MASK;
		end
	end
	a_pin3_undriven: assert property (pins_oen_o[3])
		else $error("pin three driven");
	a_reset_released: assert property ($rose(resetn_i) |-> pins_oen_o == GPP_DIR_RESET && pins_o == 6'h00)
		else $error("outputs active after reset");
	a_read_idle: assert property (!reg_re_i |=> reg_rdata_o == 8'h00)
		else $error("read data without a read");
	a_dir_fixed: assert property (reg_re_i && reg_addr_i == GPP_OFS_DIRECTION |=>
		reg_rdata_o[3] && reg_rdata_o[7:6] == 2'b00) else $error("direction fixed bits wrong");
	a_alt_gap: assert property (reg_re_i && reg_addr_i == GPP_OFS_ALT_PIN |=> !reg_rdata_o[4])
		else $error("select bit four set");
	a_latch_gap: assert property (reg_re_i && reg_addr_i == GPP_OFS_OUT_LATCH |=>
		reg_rdata_o[7:6] == 2'b00 && !reg_rdata_o[3]) else $error("latch gap bits set");
	a_unmapped_zero: assert property (reg_re_i && reg_addr_i > GPP_OFS_ALT_PIN |=> reg_rdata_o == 8'h00)
		else $error("unmapped read not zero");
	a_analog_zero: assert property (reg_re_i && reg_addr_i == GPP_OFS_PIN_LEVEL |=>
		(reg_rdata_o[5:0] & ana_r) == 6'h00) else $error("analog pin read as one");
	a_od_sink: assert property ((pins_o & $past(od_r)) == 6'h00)
		else $error("open-drain pin driven high");
	c_level_read: cover property (reg_re_i && reg_addr_i == GPP_OFS_PIN_LEVEL);
	c_alt_write: cover property (reg_we_i && reg_addr_i == GPP_OFS_ALT_PIN);
	c_pin_driven: cover property (pins_oen_o != GPP_DIR_RESET);
endmodule : gpp_port_monitor

// >>> tb/gpp_port_with_pin_steering_test.sv
// Purpose: Self-checking bench for the six-pin port with pin steering.
// Assumes: One clock; strobes last one cycle, read data follows.
// Notes:   Odd passes steer peripherals, even passes use direction and open drain.
`timescale 1ns/10ps
module gpp_port_with_pin_steering_test;
	import gpp_pkg::*;
	logic            clk_sys_i, resetn_i, reg_we_i, reg_re_i;
	gpp_addr_t       reg_addr_i;
	gpp_data_t       reg_wdata_i, reg_rdata_o;
	gpp_pins_t       pins_i, pins_o, pins_oen_o, ext_r;
	gpp_periph_out_s periph_out_i;
	gpp_periph_in_s  periph_in_o;
	int              miscompares = 0;
	int              cmp_count = 0;
	int              fsel[6] = '{6, 5, 0, 2, 1, 7};
	int              fhi[6] = '{5, 4, 5, 4, 4, 5};
	int              flo[6] = '{2, 0, 1, 0, 0, 1};
	logic [7:0]      msk[7] = '{8'h00, 8'h37, 8'h37, 8'h17, 8'h37, 8'hef, 8'h00};
	logic [7:0]      rst[8] = '{8'h28, 8'h3f, 8'h00, 8'h17, 8'h00, 8'h00, 8'h00, 8'h00};
	gpp_port u_dut (.clk_sys_i, .resetn_i, .reg_addr_i, .reg_wdata_i, .reg_we_i, .reg_re_i, .reg_rdata_o,
		.pins_i, .pins_o, .pins_oen_o, .periph_out_i, .periph_in_o);
	gpp_pin_model u_pins (.out_i(pins_o), .oen_n_i(pins_oen_o), .ext_i(ext_r), .wire_o(pins_i));
	initial begin
		clk_sys_i = 1'b0;
		forever #2.5 clk_sys_i = ~clk_sys_i;
	end
	task automatic tally_and_finish;
		if (miscompares == 0 && cmp_count > 0) begin
			$display("SIMULATION PASSED");
		end else begin
			$display("SIMULATION FAILED");
		end
		$finish;
	endtask : tally_and_finish
	task automatic chk(input string nm, input logic [7:0] exp, input logic [7:0] got);
		cmp_count++;
		if (got !== exp) begin
			miscompares++;
			$display("wrong value %s expected %h seen %h", nm, exp, got);
		end
	endtask : chk
	task automatic bus(input logic we, input gpp_addr_t a, input gpp_data_t d);
		@(posedge clk_sys_i);
		reg_we_i <= we;
		reg_re_i <= ~we;
		reg_addr_i <= a;
		reg_wdata_i <= d;
		@(posedge clk_sys_i);
		reg_we_i <= 1'b0;
		reg_re_i <= 1'b0;
		#1;
	endtask : bus
	initial begin
		logic [7:0]  v[7];
		logic [11:0] per;
		logic [7:0]  steer;
		gpp_pins_t   dir, ana, od, oen, po, w, lv, e;
		logic        d, fo;
		resetn_i = 1'b0;
		reg_we_i = 1'b0;
		reg_re_i = 1'b0;
		reg_addr_i = 4'h0;
		reg_wdata_i = 8'h00;
		periph_out_i = '0;
		ext_r = 6'h2a;
		void'($urandom(32'h9245));
		repeat (16) @(posedge clk_sys_i);
		resetn_i <= 1'b1;
		// Let the pin synchroniser fill before the first pin-level read
		repeat (2) @(posedge clk_sys_i);
		for (int a = 0; a < 8; a++) begin
			bus(1'b0, 4'(a), 8'h00);
			chk("reset value", rst[a], reg_rdata_o);
		end
		for (int i = 0; i < 40; i++) begin
			foreach (v[a]) v[a] = 8'($urandom);
			per = i[0] ? 12'($urandom) : 12'h000;
			e = 6'($urandom);
			@(posedge clk_sys_i);
			periph_out_i <= per;
			ext_r <= e;
			for (int a = 1; a < 7; a++) bus(1'b1, (a == 2 && i[1]) ? GPP_OFS_PIN_LEVEL : 4'(a), v[a]);
			for (int a = 1; a < 7; a++) begin
				bus(1'b0, 4'(a), 8'h00);
				chk("register", (v[a] & msk[a]) | (a == 1 ? 8'h08 : 8'h00), reg_rdata_o);
			end
			dir = v[1][5:0] | 6'h08;
			ana = v[3][5:0] & 6'h17;
			od = v[4][5:0] & 6'h37;
			for (int p = 0; p < 6; p++) begin
				d = v[2][p];
				fo = 1'b0;
				// Lowest priority first so the highest enabled one wins
				for (int f = 5; f >= 0; f--) begin
					if (per[2*f+1] && (v[5][fsel[f]] ? fhi[f] : flo[f]) == p) begin
						d = per[2*f];
						// Serial transmit and receive own their pin's driver
						fo = (f == 3 || f == 5);
					end
				end
				oen[p] = (dir[p] & ~fo) | (od[p] & d);
				po[p] = d & ~od[p];
				w[p] = oen[p] ? e[p] : po[p];
			end
			lv = w & ~ana;
			steer = {5'b0, lv[v[5][7] ? 5 : 1], lv[v[5][2] ? 4 : 0], lv[v[5][3] ? 3 : 4]};
			repeat (2) @(posedge clk_sys_i);
			#1;
			chk("enables", {2'b00, oen}, {2'b00, pins_oen_o});
			chk("outputs", {2'b00, po & ~oen}, {2'b00, pins_o & ~oen});
			chk("steered inputs", steer, {5'b0, periph_in_o});
			bus(1'b0, GPP_OFS_PIN_LEVEL, 8'h00);
			chk("pin levels", {2'b00, lv}, reg_rdata_o);
		end
		tally_and_finish();
	end
	initial begin
		repeat (20000) @(posedge clk_sys_i);
		miscompares++;
		tally_and_finish();
	end
endmodule : gpp_port_with_pin_steering_test
bind gpp_port gpp_port_monitor u_mon (.clk_sys_i, .resetn_i, .reg_addr_i, .reg_wdata_i, .reg_we_i,
	.reg_re_i, .reg_rdata_o, .pins_o, .pins_oen_o);
